/* File: hdl/ahbm_bus_master.sv */
// Summary of operation
// - cached normal reads: low address, size meaningless
// - cache hit aborts speculative cycle, no strobe
// - early/operand start asserted when bus free
// - prefetch starts at most every third clock
// - hits while busy show nothing externally
// - address strobe starts cycle; data strobe with it on reads, one clock later on writes
// - unlimited waits, whole clocks, three clock minimum
// - ack may precede data; late error honoured
// - inputs recognised two edges after the sampling edge
// - read data latched edge after ack recognised
// - early held ack gives no wait states
// - keep sampling both acks every wait edge
`timescale 1ns/1ps
`default_nettype none
`include "ahbm_cfg.svh"
module ahbm_bus_master (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// sequencer request
	input wire logic reqValid,
	input wire logic reqPrefetch,
	input wire logic reqWrite,
	input wire logic reqFirst,
	input wire logic [31:0] reqAddr,
	input wire logic [1:0] reqSize,
	input wire logic [31:0] reqWdata,
	input wire logic cacheEnable,
	input wire logic cacheHit,
	output logic reqReady,
	// sequencer answer
	output logic rspValid,
	output logic [31:0] rspData,
	output ahbm_pkg::ahbm_port_e rspPortWidth,
	output logic rspBusError,
	// bus strobes and cycle starts
	output logic addressStrobeN,
	output logic dataStrobeN,
	output logic earlyCycleStartN,
	output logic operandCycleStartN,
	// address, size, direction
	output logic [31:0] busAddr,
	output logic xferSizeBit0,
	output logic xferSizeBit1,
	output logic readWriteN,
	// data bus, three signals per pin
	input wire logic [31:0] dataIn,
	output logic [31:0] dataOut,
	output logic dataOe,
	// termination inputs
	input wire logic portAckLowN,
	input wire logic portAckHighN,
	input wire logic busErrorInN,
	input wire logic haltInN
);
	ahbm_pkg::ahbm_state_e state_ff;
	ahbm_pkg::ahbm_state_e nxt_state;

	ahbm_sync_if #(.W(36)) pinSync ();

	ahbm_sync #(
		.W(36),
		.RST_VAL(`AHBM_SYNC_RST)
	) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.sif(pinSync.dst)
	);

	assign pinSync.raw = {portAckHighN, portAckLowN, busErrorInN, haltInN, dataIn};

	// recognised levels, one per sampling edge
	wire logic ackHigh = ~pinSync.synced[35];
	wire logic ackLow = ~pinSync.synced[34];
	wire logic berrSeen = ~pinSync.synced[33];
	wire logic haltSeen = ~pinSync.synced[32];
	wire logic [31:0] dataSeen = pinSync.synced[31:0];
	wire logic ackAny = ackHigh | ackLow;

	// held request
	logic prefetch_ff;
	logic write_ff;
	logic first_ff;
	logic cached_ff;
	logic [31:0] addr_ff;
	logic [1:0] size_ff;
	logic [31:0] wdata_ff;
	logic [31:0] rdata_ff;
	ahbm_pkg::ahbm_port_e width_ff;
	logic [1:0] pfAgo_ff;
	logic [1:0] cycCnt_ff;

	// outputs
	logic reqReady_ff;
	logic rspValid_ff;
	logic rspBusError_ff;
	logic asN_ff;
	logic dsN_ff;
	logic ecsN_ff;
	logic ocsN_ff;
	logic oe_ff;
	logic rdWrN_ff;
	logic [31:0] busAddr_ff;
	logic [1:0] busSize_ff;

	// prefetch spacing: a start up to two clocks after a prefetch start must be data
	wire logic pfBlocked = pfAgo_ff < `AHBM_PF_SPACING;
	wire logic take = reqValid & reqReady_ff & ~(reqPrefetch & pfBlocked);
	wire logic hitAbort = (state_ff == ahbm_pkg::ST_START) & prefetch_ff & cacheHit;
	wire logic minMet = cycCnt_ff >= 2'(`AHBM_MIN_CYCLE_CLKS - 1);
	wire logic errEnd = berrSeen & ~haltSeen;
	wire logic retryEnd = berrSeen & haltSeen;
	wire logic lateErr = (state_ff == ahbm_pkg::ST_LATCH) & berrSeen;
	wire logic isRead = ~write_ff;

	// width decode of the acknowledge pair
	wire ahbm_pkg::ahbm_port_e ackWidth =
		(ackHigh & ackLow) ? ahbm_pkg::PORT_32 :
		ackHigh ? ahbm_pkg::PORT_16 :
		ackLow ? ahbm_pkg::PORT_8 : ahbm_pkg::PORT_NONE;

	// cached normal reads drive fixed low bits and long size
	wire logic dontCare = cached_ff & isRead;
	wire logic [31:0] driveAddr = dontCare ? {addr_ff[31:2], `AHBM_ADDR_LOW_IDLE} : addr_ff;
	wire logic [1:0] driveSize = dontCare ? `AHBM_SIZE_LONG : size_ff;
	// same rule from the take edge, so the low bits never change under the strobe
	wire logic takeCached = cacheEnable & ~reqWrite;
	wire logic [31:0] takeAddr = takeCached ? {reqAddr[31:2], `AHBM_ADDR_LOW_IDLE} : reqAddr;
	wire logic [1:0] takeSize = takeCached ? `AHBM_SIZE_LONG : reqSize;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ahbm_pkg::ST_IDLE:
				if (take)
					nxt_state = ahbm_pkg::ST_START;
			ahbm_pkg::ST_START:
				// strobe is held back until the cache lookup has answered
				if (hitAbort)
					nxt_state = ahbm_pkg::ST_IDLE;
				else
					nxt_state = ahbm_pkg::ST_STROBE;
			ahbm_pkg::ST_STROBE:
				nxt_state = ahbm_pkg::ST_WAITACK;
			ahbm_pkg::ST_WAITACK:
				// no timeout: waits last as long as the slave needs
				if (ackAny | berrSeen)
					nxt_state = ahbm_pkg::ST_LATCH;
			ahbm_pkg::ST_LATCH:
				nxt_state = ahbm_pkg::ST_END;
			ahbm_pkg::ST_END:
				if (minMet)
					nxt_state = (rspValid_ff | rspBusError_ff) ?
						ahbm_pkg::ST_IDLE : ahbm_pkg::ST_START;
			default:
				nxt_state = ahbm_pkg::ST_IDLE;
		endcase
	end

	wire logic busy = (nxt_state != ahbm_pkg::ST_IDLE);
	wire logic strobing = (nxt_state == ahbm_pkg::ST_STROBE) |
		(nxt_state == ahbm_pkg::ST_WAITACK) | (nxt_state == ahbm_pkg::ST_LATCH);
	wire logic nxt_ecsN = ~(nxt_state == ahbm_pkg::ST_START);
	wire logic nxt_ocsN = ~((nxt_state == ahbm_pkg::ST_START) &
		(take ? reqFirst : first_ff));
	// reads strobe data with the address; writes one clock later, data then stable
	wire logic nxt_dsN = ~(strobing & (isRead | (state_ff != ahbm_pkg::ST_START)));

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			state_ff <= ahbm_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// captured request
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			prefetch_ff <= 1'b0;
			write_ff <= 1'b0;
			first_ff <= 1'b0;
			cached_ff <= 1'b0;
			addr_ff <= 32'h0000_0000;
			size_ff <= `AHBM_SIZE_LONG;
			wdata_ff <= 32'h0000_0000;
		end
		else if (take)
		begin
			prefetch_ff <= reqPrefetch;
			write_ff <= reqWrite;
			first_ff <= reqFirst;
			cached_ff <= cacheEnable;
			addr_ff <= reqAddr;
			size_ff <= reqSize;
			wdata_ff <= reqWdata;
		end
	end

	// prefetch spacing and least cycle length
	always_ff @(posedge mclk)
	begin
		if (!rstn)
			pfAgo_ff <= `AHBM_PF_SPACING;
		else if (take & reqPrefetch)
			pfAgo_ff <= 2'h0;
		else if (pfBlocked)
			pfAgo_ff <= pfAgo_ff + 2'h1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			cycCnt_ff <= 2'h0;
		else if (nxt_state == ahbm_pkg::ST_STROBE)
			cycCnt_ff <= 2'h0;
		else if (!minMet)
			cycCnt_ff <= cycCnt_ff + 2'h1;
	end

	// width on the edge the ack is recognised; data latch one edge after
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			rdata_ff <= 32'h0000_0000;
			width_ff <= ahbm_pkg::PORT_NONE;
		end
		else if (state_ff == ahbm_pkg::ST_WAITACK && ackAny)
			width_ff <= ackWidth;
		else if (state_ff == ahbm_pkg::ST_LATCH && isRead)
			rdata_ff <= dataSeen;
	end

	// answer to the sequencer
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			rspValid_ff <= 1'b0;
			rspBusError_ff <= 1'b0;
		end
		else
		begin
			// error beats a good ack that came first; retry answers nothing
			rspValid_ff <= lateErr ? 1'b0 :
				((state_ff == ahbm_pkg::ST_LATCH) & ~rspValid_ff);
			rspBusError_ff <= lateErr & errEnd;
			if (state_ff == ahbm_pkg::ST_END && minMet)
			begin
				rspValid_ff <= 1'b0;
				rspBusError_ff <= 1'b0;
			end
		end
	end

	// bus pins
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			reqReady_ff <= 1'b0;
			asN_ff <= 1'b1;
			dsN_ff <= 1'b1;
			ecsN_ff <= 1'b1;
			ocsN_ff <= 1'b1;
			oe_ff <= 1'b0;
			rdWrN_ff <= 1'b1;
			busAddr_ff <= 32'h0000_0000;
			busSize_ff <= `AHBM_SIZE_LONG;
		end
		else
		begin
			reqReady_ff <= ~busy;
			asN_ff <= ~strobing;
			dsN_ff <= nxt_dsN;
			ecsN_ff <= nxt_ecsN;
			ocsN_ff <= nxt_ocsN;
			oe_ff <= busy & (take ? reqWrite : write_ff);
			rdWrN_ff <= busy ? ~(take ? reqWrite : write_ff) : 1'b1;
			busAddr_ff <= take ? takeAddr : driveAddr;
			busSize_ff <= take ? takeSize : driveSize;
		end
	end

	assign reqReady = reqReady_ff;
	assign rspValid = rspValid_ff;
	assign rspData = rdata_ff;
	assign rspPortWidth = width_ff;
	assign rspBusError = rspBusError_ff;
	assign addressStrobeN = asN_ff;
	assign dataStrobeN = dsN_ff;
	assign earlyCycleStartN = ecsN_ff;
	assign operandCycleStartN = ocsN_ff;
	assign busAddr = busAddr_ff;
	assign xferSizeBit0 = busSize_ff[0];
	assign xferSizeBit1 = busSize_ff[1];
	assign readWriteN = rdWrN_ff;
	assign dataOut = wdata_ff;
	assign dataOe = oe_ff;
endmodule // ahbm_bus_master
`default_nettype wire

/* File: hdl/ahbm_cfg.svh */
`ifndef AHBM_CFG_SVH
`define AHBM_CFG_SVH

// synchroniser depth for every pin input
`define AHBM_SYNC_STAGES 2
// least clocks from strobe assertion to strobe negation
`define AHBM_MIN_CYCLE_CLKS 3
// prefetch starts at most every third clock
`define AHBM_PF_SPACING 2'h2
// transfer size encodings
`define AHBM_SIZE_LONG 2'h0
`define AHBM_SIZE_BYTE 2'h1
`define AHBM_SIZE_WORD 2'h2
`define AHBM_SIZE_THREE 2'h3
// low address bits driven when they carry no meaning
`define AHBM_ADDR_LOW_IDLE 2'h0
// reset level of the synchronised pins: ack, error, halt high, data zero
`define AHBM_SYNC_RST {4'hF, 32'h0000_0000}

`endif

/* File: hdl/ahbm_pkg.sv */
package ahbm_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_STROBE,
		ST_WAITACK,
		ST_LATCH,
		ST_END
	} ahbm_state_e;

	typedef enum logic [1:0] {
		PORT_NONE,
		PORT_8,
		PORT_16,
		PORT_32
	} ahbm_port_e;

	typedef enum logic [1:0] {
		END_OK,
		END_ERROR,
		END_RETRY
	} ahbm_end_e;
endpackage

/* File: hdl/ahbm_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ahbm_sync_if #(
	parameter int W = 36
);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport src (output raw, input synced);
	modport dst (input raw, output synced);
endinterface
`default_nettype wire

/* File: hdl/ahbm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ahbm_cfg.svh"
module ahbm_sync #(
	parameter int W = 36,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// pins in, synchronised out
	ahbm_sync_if.dst sif
);
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic [`AHBM_SYNC_STAGES-1:0] stage_ff;
			// only the last stage is read outside this chain
			always_ff @(posedge mclk)
			begin
				if (!rstn)
					stage_ff <= {`AHBM_SYNC_STAGES{RST_VAL[i]}};
				else
					stage_ff <= {stage_ff[`AHBM_SYNC_STAGES-2:0], sif.raw[i]};
			end
			assign sif.synced[i] = stage_ff[`AHBM_SYNC_STAGES-1];
		end
	endgenerate
endmodule // ahbm_sync
`default_nettype wire

/* File: dv/ahbm_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ahbm_slave_model (
	// clock and strobe
	input wire logic mclk,
	input wire logic addressStrobeN,
	// response setup
	input wire logic [3:0] waitCnt,
	input wire ahbm_pkg::ahbm_port_e portW,
	input wire logic [1:0] errMode,
	input wire logic [31:0] rdVal,
	// termination and read data
	output logic portAckLowN,
	output logic portAckHighN,
	output logic busErrorInN,
	output logic haltInN,
	output logic [31:0] dataIn
);
	logic [3:0] cnt_ff;
	logic rty_ff;
	wire hit = !addressStrobeN && cnt_ff == waitCnt;
	wire late = !addressStrobeN && cnt_ff == waitCnt + 4'h1;
	wire held = !addressStrobeN && cnt_ff > waitCnt;
	// mode 2 asks for a retry once, then lets the repeated cycle through
	wire askRetry = errMode == 2'h2 && !rty_ff;
	wire ackOk = errMode != 2'h1 && !askRetry;
	initial {cnt_ff, rty_ff, portAckHighN, portAckLowN, busErrorInN, haltInN, dataIn} = {5'h00, 4'hF, 32'h5A5A_A5A5};
	always @(posedge mclk)
	begin
		cnt_ff <= addressStrobeN ? 4'h0 : cnt_ff + 4'h1;
		rty_ff <= errMode == 2'h2 && (rty_ff || !haltInN);
		// undriven data toggles so a stale value is never latched by luck
		dataIn <= hit ? rdVal : (held ? dataIn : ~dataIn);
		if (addressStrobeN)
			{portAckHighN, portAckLowN, busErrorInN, haltInN} <= 4'hF;
		else if (hit)
		begin
			portAckHighN <= !ackOk || portW == ahbm_pkg::PORT_8;
			portAckLowN <= !ackOk || portW == ahbm_pkg::PORT_16;
			busErrorInN <= !(errMode == 2'h1 || askRetry);
			haltInN <= !askRetry;
		end
		else if (late && errMode == 2'h3)
			busErrorInN <= 1'b0;
	end
endmodule // ahbm_slave_model
`default_nettype wire

/* File: dv/ahbm_bus_master_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ahbm_bus_master_props (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// request side
	input wire logic reqValid,
	input wire logic reqReady,
	input wire logic reqPrefetch,
	input wire logic reqWrite,
	input wire logic cacheEnable,
	input wire logic cacheHit,
	// bus side
	input wire logic addressStrobeN,
	input wire logic dataStrobeN,
	input wire logic earlyCycleStartN,
	input wire logic operandCycleStartN,
	input wire logic [31:0] busAddr,
	input wire logic xferSizeBit0,
	input wire logic xferSizeBit1,
	input wire logic readWriteN,
	input wire logic dataOe,
	input wire logic portAckLowN,
	input wire logic portAckHighN,
	input wire logic busErrorInN
);
	wire noTerm = portAckLowN & portAckHighN & busErrorInN;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence pfTake;
		reqValid && reqReady && reqPrefetch ##1 !earlyCycleStartN;
	endsequence
	sequence pfHit;
		reqValid && reqReady && reqPrefetch ##1 !earlyCycleStartN && cacheHit;
	endsequence
	sequence pfAgain;
		pfTake ##1 (reqValid && reqReady && reqPrefetch);
	endsequence
	sequence readTake;
		reqValid && reqReady && cacheEnable && !reqWrite && !reqPrefetch ##1 !earlyCycleStartN;
	endsequence
	a_hit_no_strobe: assert property (pfHit |=> addressStrobeN [*2]) else $error("strobe on hit");
	a_pf_spacing: assert property (pfAgain |=> earlyCycleStartN) else $error("early prefetch");
	a_strobe_after_start: assert property ($fell(addressStrobeN) |-> $past(!earlyCycleStartN)) else $error("no start");
	a_start_bus_free: assert property (!earlyCycleStartN |-> addressStrobeN) else $error("start busy");
	a_operand_start: assert property (!operandCycleStartN |-> !earlyCycleStartN) else $error("lone operand");
	a_min_cycle: assert property ($fell(addressStrobeN) |-> !addressStrobeN [*3]) else $error("short cycle");
	a_write_ds_late: assert property ($fell(addressStrobeN) && !readWriteN |-> dataStrobeN ##1 !dataStrobeN) else $error("write ds");
	a_read_ds_with: assert property ($fell(addressStrobeN) && readWriteN |-> !dataStrobeN) else $error("read ds");
	a_oe_on_write: assert property (dataOe |-> !readWriteN) else $error("oe on read");
	a_cached_low: assert property (readTake |-> busAddr[1:0] == 2'h0 && {xferSizeBit1, xferSizeBit0} == 2'h0) else $error("cached low bits");
	a_wait_no_ack: assert property (!addressStrobeN && noTerm && $past(noTerm) && $past(noTerm, 2) && $past(noTerm, 3) |=> !addressStrobeN) else $error("ended unacked");
endmodule // ahbm_bus_master_props
bind ahbm_bus_master ahbm_bus_master_props ahbm_bus_master_props_inst (.mclk(mclk), .rstn(rstn),
	.reqValid(reqValid), .reqReady(reqReady), .reqPrefetch(reqPrefetch), .reqWrite(reqWrite),
	.cacheEnable(cacheEnable), .cacheHit(cacheHit), .addressStrobeN(addressStrobeN),
	.dataStrobeN(dataStrobeN), .earlyCycleStartN(earlyCycleStartN),
	.operandCycleStartN(operandCycleStartN), .busAddr(busAddr), .xferSizeBit0(xferSizeBit0),
	.xferSizeBit1(xferSizeBit1), .readWriteN(readWriteN), .dataOe(dataOe),
	.portAckLowN(portAckLowN), .portAckHighN(portAckHighN), .busErrorInN(busErrorInN));
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk = 1'b0, rstn = 1'b0, reqValid = 1'b0, reqPrefetch = 1'b0, reqWrite = 1'b0;
	logic reqFirst = 1'b0, cacheEnable = 1'b0, cacheHit = 1'b0;
	logic [31:0] reqAddr = 32'h0, reqWdata = 32'h0, rdVal = 32'h0;
	logic [1:0] reqSize = 2'h0, errMode = 2'h0;
	logic [3:0] waitCnt = 4'h0, asLow;
	ahbm_pkg::ahbm_port_e portW = ahbm_pkg::PORT_32, rspPortWidth;
	logic reqReady, rspValid, rspBusError, addressStrobeN, dataStrobeN, earlyCycleStartN;
	logic operandCycleStartN, xferSizeBit0, xferSizeBit1, readWriteN, dataOe, gotV, gotB;
	logic portAckLowN, portAckHighN, busErrorInN, haltInN;
	logic [31:0] rspData, busAddr, dataIn, dataOut, seenW;
	int err_total = 0, checked = 0, asFalls = 0, n, waits;
	ahbm_bus_master ahbm_bus_master_inst (.mclk(mclk), .rstn(rstn), .reqValid(reqValid),
		.reqPrefetch(reqPrefetch), .reqWrite(reqWrite), .reqFirst(reqFirst), .reqAddr(reqAddr),
		.reqSize(reqSize), .reqWdata(reqWdata), .cacheEnable(cacheEnable), .cacheHit(cacheHit),
		.reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspPortWidth(rspPortWidth),
		.rspBusError(rspBusError), .addressStrobeN(addressStrobeN), .dataStrobeN(dataStrobeN),
		.earlyCycleStartN(earlyCycleStartN), .operandCycleStartN(operandCycleStartN),
		.busAddr(busAddr), .xferSizeBit0(xferSizeBit0), .xferSizeBit1(xferSizeBit1),
		.readWriteN(readWriteN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.portAckLowN(portAckLowN), .portAckHighN(portAckHighN), .busErrorInN(busErrorInN),
		.haltInN(haltInN));
	ahbm_slave_model ahbm_slave_model_inst (.mclk(mclk), .addressStrobeN(addressStrobeN),
		.waitCnt(waitCnt), .portW(portW), .errMode(errMode), .rdVal(rdVal),
		.portAckLowN(portAckLowN), .portAckHighN(portAckHighN), .busErrorInN(busErrorInN),
		.haltInN(haltInN), .dataIn(dataIn));
	always #12.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		if ($fell(addressStrobeN))
		begin
			asFalls++;
			asLow <= {busAddr[1:0], xferSizeBit1, xferSizeBit0};
		end
		if (dataOe)
			seenW <= dataOut;
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task req(input logic pf, input logic wr, input logic ce, input logic [31:0] ad);
		repeat (100) if (reqReady !== 1'b1) @(posedge mclk) #2;
		{reqValid, reqPrefetch, reqWrite, reqFirst, cacheEnable} = {1'b1, pf, wr, !pf, ce};
		reqAddr = ad;
		reqWdata = ~ad;
		waits = 0;
		// hold the request until it is taken; a refused one stays up
		repeat (100) if (reqValid)
		begin
			@(posedge mclk) #2;
			waits++;
			if (reqReady !== 1'b1)
				reqValid = 1'b0;
		end
	endtask
	task rsp(input logic expV, input string nm);
		gotV = 1'b0;
		gotB = 1'b0;
		repeat (100) if (!(gotV | gotB))
		begin
			@(posedge mclk) #2;
			gotV = rspValid === 1'b1;
			gotB = rspBusError === 1'b1;
		end
		chk({nm, " done"}, 32'(gotV), 32'(expV));
		chk({nm, " error"}, 32'(gotB), 32'(!expV));
	endtask
	task t_ports;
		for (int i = 0; i < 6; i++)
		begin
			portW = ahbm_pkg::ahbm_port_e'(1 + i % 3);
			waitCnt = 4'(i / 3 * 5);
			rdVal = 32'hC0DE_0000 + 32'(i);
			req(1'b0, 1'b0, 1'b0, 32'h0000_0100);
			rsp(1'b1, "read");
			chk("width", 32'(rspPortWidth), 32'(portW));
			chk("rdata", rspData, rdVal);
		end
	endtask
	task t_write;
		req(1'b0, 1'b1, 1'b0, 32'h0000_0204);
		rsp(1'b1, "write");
		chk("wdata", seenW, 32'hFFFF_FDFB);
	endtask
	task t_err;
		waitCnt = 4'h0;
		for (int m = 1; m < 4; m++)
		begin
			errMode = 2'(m);
			n = asFalls;
			req(1'b0, 1'b0, 1'b0, 32'h0000_0300);
			rsp(m == 2, "terminate");
			chk("strobes", 32'(asFalls - n), m == 2 ? 32'h2 : 32'h1);
		end
		errMode = 2'h0;
	endtask
	task t_cached;
		reqSize = 2'h1;
		req(1'b0, 1'b0, 1'b1, 32'h0000_0103);
		rsp(1'b1, "cached");
		chk("low bits", 32'(asLow), 32'h0);
		req(1'b0, 1'b0, 1'b0, 32'h0000_0103);
		rsp(1'b1, "uncached");
		chk("plain low bits", 32'(asLow), 32'hD);
	endtask
	task t_hit;
		n = asFalls;
		req(1'b1, 1'b0, 1'b0, 32'h0000_0400);
		cacheHit = 1'b1;
		req(1'b1, 1'b0, 1'b0, 32'h0000_0480);
		chk("prefetch waits", 32'(waits), 32'h2);
		req(1'b0, 1'b0, 1'b0, 32'h0000_0500);
		chk("data waits", 32'(waits), 32'h1);
		cacheHit = 1'b0;
		rsp(1'b1, "after hit");
		chk("hit strobes", 32'(asFalls - n), 32'h1);
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_total++;
		wrap_up;
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		#2 rstn = 1'b1;
		t_ports;
		t_write;
		t_err;
		t_cached;
		t_hit;
		wrap_up;
	end
endmodule // tb
`default_nettype wire
